//--- shared/tkc_pkg.sv
package tkc_pkg;
  // ---------------------------------------------
  // Register offsets (addr bit 5 = block select)
  // ---------------------------------------------
  localparam logic [5:0] OFS_TMR0_CTL = 6'h01;
  localparam logic [5:0] OFS_TMR1_CTL = 6'h02;
  localparam logic [5:0] OFS_PERIODIC = 6'h03;
  localparam logic [5:0] OFS_STEERING = 6'h04;
  localparam logic [5:0] OFS_TMR0_LSB = 6'h0f;
  localparam logic [5:0] OFS_TMR0_MSB = 6'h10;
  localparam logic [5:0] OFS_TMR1_LSB = 6'h11;
  localparam logic [5:0] OFS_TMR1_MSB = 6'h12;
  localparam logic [5:0] OFS_CLK_MODE = 6'h21;
  // ---------------------------------------------
  // Timer control fields
  // ---------------------------------------------
  localparam int TC_RUN = 0;
  localparam int TC_MODE_LO = 1;
  localparam int TC_CSEL_LO = 3;
  localparam int TC_LATCH = 6;
  localparam int TC_SUSP = 7;
  localparam logic [1:0] MODE_ONESHOT = 2'h0;
  localparam logic [1:0] MODE_GATED = 2'h3;
  // ---------------------------------------------
  // Periodic, steering and mode fields
  // ---------------------------------------------
  localparam int PF_OSC = 6;
  localparam int PF_TEST = 7;
  localparam int ST_DELAY = 5;
  localparam int ST_LOWBAT = 6;
  localparam int ST_TSAVE = 7;
  localparam int CM_H12 = 2;
  localparam int CM_RUN = 3;
  localparam int CM_SBIRQ = 4;
  localparam int CM_SBTMR = 5;
  localparam int CM_XTAL_LO = 6;
  localparam logic [1:0] MFO_IRQ2 = 2'h0;
  localparam logic [1:0] MFO_TMR0 = 2'h1;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  localparam int MCLK_MHZ = 125;
  localparam int LOCK_LONG_US = 480;
  localparam int LOCK_SHORT_US = 30;
  localparam int LOCK_LONG_CYC = LOCK_LONG_US * MCLK_MHZ;
  localparam int LOCK_SHORT_CYC = LOCK_SHORT_US * MCLK_MHZ;
endpackage : tkc_pkg

//--- shared/tkc_timer_if.sv
`timescale 1ns/1ps
// Control and status between register file and one timer
interface tkc_timer_if;
  logic run;         // Run enable
  logic [1:0] mode;  // Count mode
  logic [2:0] csel;  // Clock source select
  logic suspend;     // Suspend in modes 0..2
  logic trigger;     // Mode 3 trigger pulse
  logic [15:0] reload;
  logic timeout;     // Pulse at terminal count
  logic [15:0] value;
  modport ctl (output run, mode, csel, suspend, trigger, reload, input timeout, value);
  modport tmr (input run, mode, csel, suspend, trigger, reload, output timeout, value);
endinterface : tkc_timer_if

//--- hdl/tkc_timer.sv
`timescale 1ns/1ps
module tkc_timer
  import tkc_pkg::*;
#(
  parameter int PRE_W = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] tick_i,
  tkc_timer_if.tmr ctl
);
  logic [PRE_W-1:0] presc; // Prescaler
  logic [15:0] count;      // Down counter
  logic armed;             // Mode 3 sequence active
  logic tick;
  logic pre_wrap;
  assign tick = tick_i[ctl.csel];
  assign pre_wrap = tick && (presc == {PRE_W{1'b1}});
  assign ctl.value = count;
  // ---------------------------------------------
  // Prescaler: cleared whenever stopped
  // ---------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      presc <= '0;
    end else if (!ctl.run) begin
      presc <= '0;
    end else if (tick && !(ctl.suspend && ctl.mode != MODE_GATED)) begin
      presc <= presc + 1'b1;
    end
  end
  // ---------------------------------------------
  // Counter and terminal count
  // ---------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 16'hffff;
      armed <= 1'b0;
      ctl.timeout <= 1'b0;
    end else begin
      ctl.timeout <= 1'b0;
      if (!ctl.run) begin
        count <= ctl.reload;
        armed <= 1'b0;
      end else if (ctl.mode == MODE_GATED && ctl.trigger) begin
        count <= ctl.reload;
        armed <= 1'b1;
      end else if (pre_wrap && !(ctl.suspend && ctl.mode != MODE_GATED)
                   && (ctl.mode != MODE_GATED || armed)) begin
        if (count == 16'h0000) begin
          ctl.timeout <= 1'b1;
          count <= ctl.reload;
          armed <= 1'b0;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule : tkc_timer

//--- hdl/tkc_power_fail_input.sv
`timescale 1ns/1ps
module tkc_power_fail_input
  import tkc_pkg::*;
#(
  parameter int LONG_CYC = LOCK_LONG_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic power_fail_input_n_i,
  input wire logic delay_en_i,
  output logic fail_pulse_o,
  output logic lockout_o
);
  logic [16:0] cnt;   // Cycles since failure seen
  logic failed;       // Power failure active
  logic fail_d;
  // ---------------------------------------------
  // Failure edge and lockout delay
  // ---------------------------------------------
  assign fail_pulse_o = !power_fail_input_n_i && !fail_d;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      fail_d <= 1'b0;
      failed <= 1'b0;
      cnt <= '0;
      lockout_o <= 1'b0;
    end else begin
      fail_d <= !power_fail_input_n_i;
      if (power_fail_input_n_i) begin
        failed <= 1'b0;
        cnt <= '0;
        lockout_o <= 1'b0;
      end else begin
        failed <= 1'b1;
        if (!lockout_o) begin
          cnt <= cnt + 1'b1;
        end
        if (failed && delay_en_i) begin
          if (cnt >= 17'(LONG_CYC - 1)) begin
            lockout_o <= 1'b1;
          end
        end else if (failed && cnt > 17'(LOCK_SHORT_CYC)) begin
          lockout_o <= 1'b1;
        end else if (failed && !delay_en_i && fail_d && cnt >= 17'(LOCK_SHORT_CYC - 1)) begin
          lockout_o <= 1'b1;
        end
      end
    end
  end
endmodule : tkc_power_fail_input

//--- hdl/tkc_top.sv
`timescale 1ns/1ps
module tkc_top
  import tkc_pkg::*;
#(
  parameter int LONG_CYC = LOCK_LONG_CYC,
  parameter int PRE_W = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic power_fail_input_n_i,
  input wire logic standby_i,
  input wire logic osc_running_i,
  input wire logic osc_fail_i,
  input wire logic [5:0] rollover_i,
  input wire logic year_end_i,
  input wire logic low_batt_i,
  input wire logic pf_irq_en_i,
  input wire logic [4:0] irq_src_i,
  input wire logic [1:0] mfo_sel_i,
  input wire logic osc_buf_i,
  input wire logic [5:0] int_tick_i,
  input wire logic ext_clk_i,
  input wire logic gate_in_zero_i,
  input wire logic gate_in_one_i,
  output logic main_irq_pin_o,
  output logic multi_function_pin_o,
  output logic timer0_wave_o,
  output logic test_mode_en_o,
  output logic single_supply_o,
  output logic time_save_track_o,
  output logic hour_12_mode_o,
  output logic clock_run_o,
  output logic [1:0] leapyear_count_o,
  output logic feb29_allow_o,
  output logic [1:0] crystal_sel_o,
  output logic standby_clear_en_o,
  output logic pins_open_drain_o,
  output logic lockout_o
);
  // ---------------------------------------------
  // Register state
  // ---------------------------------------------
  logic [7:0] tctl [2];    // Timer control registers
  logic [15:0] reload [2]; // Timer start values
  logic [15:0] hold [2];   // Latched timer values
  logic [5:0] pflags;      // Rollover flags
  logic osc_fail_flag;     // Oscillator failed
  logic supply_single;     // Supply mode select
  logic test_en;           // Test register exposure
  logic [4:0] steer;       // Interrupt steering
  logic delay_en;          // Long lockout window
  logic tsave_en;          // Time save tracking
  logic [7:0] cmode;       // Clock mode config
  logic [1:0] trig;        // Mode 3 trigger pulses
  logic [1:0] gate_d;      // Gate edge history
  logic standby_d;         // Standby entry detect
  logic fail_pulse;        // Power failure onset
  logic acc_wr;            // Write that is honoured
  logic acc_rd;            // Read that is honoured
  logic [7:0] next_rdata;  // Read mux result
  logic [7:0] ticks;       // Timer clock sources
  logic [1:0] tmo;         // Timer terminal counts
  logic [15:0] tval [2];   // Live timer values
  logic tmr_run_ok;        // Timers allowed to run
  tkc_timer_if tif0 ();
  tkc_timer_if tif1 ();

  // Decode helper shared by all write ports
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign acc_wr = wr_i && !lockout_o;
  assign acc_rd = rd_i && !lockout_o;

  // ---------------------------------------------
  // Power fail lockout
  // ---------------------------------------------
  tkc_power_fail_input #(
    .LONG_CYC(LONG_CYC)
  ) u_power_fail_input (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .power_fail_input_n_i(power_fail_input_n_i),
    .delay_en_i(delay_en),
    .fail_pulse_o(fail_pulse),
    .lockout_o(lockout_o)
  );

  // ---------------------------------------------
  // Timers
  // ---------------------------------------------
  // External clock dead in standby
  assign ticks = {ext_clk_i && !standby_i, 1'b0, int_tick_i};
  assign tmr_run_ok = !standby_i || cmode[CM_SBTMR];
  assign tif0.run = tctl[0][TC_RUN] && tmr_run_ok;
  assign tif1.run = tctl[1][TC_RUN] && tmr_run_ok;
  // Mode and clock fields drive timers
  assign tif0.mode = tctl[0][TC_MODE_LO +: 2];
  assign tif1.mode = tctl[1][TC_MODE_LO +: 2];
  assign tif0.csel = tctl[0][TC_CSEL_LO +: 3];
  assign tif1.csel = tctl[1][TC_CSEL_LO +: 3];
  assign tif0.suspend = tctl[0][TC_SUSP];
  assign tif1.suspend = tctl[1][TC_SUSP];
  assign tif0.trigger = trig[0];
  assign tif1.trigger = trig[1];
  assign tif0.reload = reload[0];
  assign tif1.reload = reload[1];
  assign tmo = {tif1.timeout, tif0.timeout};
  assign tval[0] = tif0.value;
  assign tval[1] = tif1.value;

  tkc_timer #(.PRE_W(PRE_W)) u_tmr0 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .tick_i(ticks),
    .ctl(tif0)
  );
  tkc_timer #(.PRE_W(PRE_W)) u_tmr1 (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .tick_i(ticks),
    .ctl(tif1)
  );

  // ---------------------------------------------
  // Mode 3 trigger from writes and gate pins
  // ---------------------------------------------
  // Gate rising edge retriggers like the bit
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      trig <= 2'h0;
      gate_d <= 2'h0;
    end else begin
      gate_d <= {gate_in_one_i, gate_in_zero_i} & {2{!standby_i}};
      for (int i = 0; i < 2; i++) begin
        trig[i] <= (acc_wr && hit(addr_i, 6'(OFS_TMR0_CTL + i)) && wdata_i[TC_SUSP])
                   || (!standby_i && !gate_d[i]
                       && (i == 0 ? gate_in_zero_i : gate_in_one_i));
      end
    end
  end

  // ---------------------------------------------
  // Timer control, reload and holding registers
  // ---------------------------------------------
  // Self-clear and read-clear win over nothing else
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2; i++) begin
        tctl[i] <= 8'h00;
        reload[i] <= 16'hffff;
        hold[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (acc_wr && hit(addr_i, 6'(OFS_TMR0_CTL + i))) begin
          tctl[i] <= wdata_i;
          if (wdata_i[TC_LATCH]) begin
            hold[i] <= tval[i];
          end
        end else begin
          if (tmo[i] && tctl[i][TC_MODE_LO +: 2] == MODE_ONESHOT) begin
            tctl[i][TC_RUN] <= 1'b0;
          end
          // Low byte read ends latched read
          if (acc_rd && hit(addr_i, 6'(OFS_TMR0_LSB + 2 * i))) begin
            tctl[i][TC_LATCH] <= 1'b0;
          end
        end
        if (acc_wr && hit(addr_i, 6'(OFS_TMR0_LSB + 2 * i))) begin
          reload[i][7:0] <= wdata_i;
        end
        if (acc_wr && hit(addr_i, 6'(OFS_TMR0_MSB + 2 * i))) begin
          reload[i][15:8] <= wdata_i;
        end
      end
    end
  end

  // ---------------------------------------------
  // Periodic flag register
  // ---------------------------------------------
  // New rollover in the read cycle is kept
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pflags <= 6'h00;
    end else if (acc_rd && hit(addr_i, OFS_PERIODIC)) begin
      pflags <= rollover_i;
    end else begin
      pflags <= pflags | rollover_i;
    end
  end

  // Oscillator fail flag and supply mode
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      osc_fail_flag <= 1'b1;
      supply_single <= 1'b1;
      test_en <= 1'b0;
    end else begin
      // Set on failure, cleared by clock start
      if (osc_fail_i) begin
        osc_fail_flag <= 1'b1;
      end else if (acc_wr && hit(addr_i, OFS_CLK_MODE) && wdata_i[CM_RUN] && osc_running_i) begin
        osc_fail_flag <= 1'b0;
      end
      if (osc_fail_i) begin
        supply_single <= 1'b1;
      end else if (acc_wr && hit(addr_i, OFS_PERIODIC)) begin
        supply_single <= wdata_i[PF_OSC];
      end
      if (acc_wr && hit(addr_i, OFS_PERIODIC)) begin
        test_en <= wdata_i[PF_TEST];
      end
    end
  end

  // ---------------------------------------------
  // Interrupt steering register
  // ---------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      steer <= 5'h00;
      delay_en <= 1'b0;
      tsave_en <= 1'b0;
    end else begin
      if (acc_wr && hit(addr_i, OFS_STEERING)) begin
        steer <= wdata_i[4:0];
        // Clearing here past the short window locks out at once
        delay_en <= wdata_i[ST_DELAY];
      end
      if (fail_pulse) begin
        tsave_en <= 1'b0;
      end else if (acc_wr && hit(addr_i, OFS_STEERING)) begin
        tsave_en <= wdata_i[ST_TSAVE];
      end
    end
  end

  // ---------------------------------------------
  // Clock mode register and leap year counter
  // ---------------------------------------------
  // Run bit may only rise once the crystal runs
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cmode <= 8'h00;
    end else begin
      if (acc_wr && hit(addr_i, OFS_CLK_MODE)) begin
        cmode <= wdata_i;
        // Held at zero until oscillator runs
        cmode[CM_RUN] <= wdata_i[CM_RUN] && osc_running_i && !osc_fail_i;
      end else if (year_end_i) begin
        cmode[1:0] <= cmode[1:0] + 2'h1;
      end
      if (osc_fail_i) begin
        cmode[CM_RUN] <= 1'b0;
      end
    end
  end

  // Standby entry clears enables unless kept
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      standby_d <= 1'b0;
      standby_clear_en_o <= 1'b0;
    end else begin
      standby_d <= standby_i;
      // Pulse on entry when bit is zero
      standby_clear_en_o <= standby_i && !standby_d && !cmode[CM_SBIRQ];
    end
  end

  // ---------------------------------------------
  // Read data, one cycle after the strobe
  // ---------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr_i)
      OFS_TMR0_CTL: next_rdata = tctl[0];
      OFS_TMR1_CTL: next_rdata = tctl[1];
      OFS_PERIODIC: next_rdata = {test_en, osc_fail_flag, pflags};
      // Low battery only with power fail enable
      OFS_STEERING: next_rdata = {tsave_en, low_batt_i && pf_irq_en_i, delay_en, steer};
      OFS_TMR0_LSB: next_rdata = hold[0][7:0];
      OFS_TMR0_MSB: next_rdata = hold[0][15:8];
      OFS_TMR1_LSB: next_rdata = hold[1][7:0];
      OFS_TMR1_MSB: next_rdata = hold[1][15:8];
      OFS_CLK_MODE: next_rdata = cmode;
      default: next_rdata = 8'h00;
    endcase
  end

  // Locked-out or idle cycles read as zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= acc_rd ? next_rdata : 8'h00;
    end
  end

  // ---------------------------------------------
  // Pins and mode outputs
  // ---------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      main_irq_pin_o <= 1'b0;
      multi_function_pin_o <= 1'b0;
      timer0_wave_o <= 1'b0;
    end else begin
      if (tmo[0]) begin
        timer0_wave_o <= !timer0_wave_o;
      end
      main_irq_pin_o <= |(irq_src_i & ~steer);
      if (mfo_sel_i == MFO_IRQ2) begin
        multi_function_pin_o <= |(irq_src_i & steer);
      end else if (mfo_sel_i == MFO_TMR0) begin
        multi_function_pin_o <= timer0_wave_o;
      end else begin
        multi_function_pin_o <= osc_buf_i;
      end
    end
  end

  assign test_mode_en_o = test_en;
  assign single_supply_o = supply_single;
  assign time_save_track_o = tsave_en;
  assign hour_12_mode_o = cmode[CM_H12];
  assign clock_run_o = cmode[CM_RUN];
  assign leapyear_count_o = cmode[1:0];
  // Leap day only in current leap year
  assign feb29_allow_o = (cmode[1:0] == 2'h0);
  assign crystal_sel_o = cmode[CM_XTAL_LO +: 2];
  assign pins_open_drain_o = standby_i;
endmodule : tkc_top

//--- testbench/tkc_top_checker.sv
`timescale 1ns/1ps
module tkc_top_checker
  import tkc_pkg::*;
#(
  parameter int LONG_CYC = LOCK_LONG_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] rdata_o,
  input wire logic lockout_o,
  input wire logic power_fail_input_n_i,
  input wire logic standby_i,
  input wire logic pins_open_drain_o,
  input wire logic standby_clear_en_o,
  input wire logic [1:0] leapyear_count_o,
  input wire logic feb29_allow_o,
  input wire logic [1:0] mfo_sel_i,
  input wire logic osc_buf_i,
  input wire logic multi_function_pin_o,
  input wire logic osc_fail_i,
  input wire logic clock_run_o,
  input wire logic time_save_track_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Cycles spent in power failure; saturates so it never wraps
  int unsigned fail_cnt;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i)
      fail_cnt <= 0;
    else if (power_fail_input_n_i)
      fail_cnt <= 0;
    else if (fail_cnt < 100000)
      fail_cnt <= fail_cnt + 1;
  end
  AST_LOCK_RD: assert property (lockout_o |=> rdata_o == 8'h00)
    else $error("read data not zero while locked");
  AST_LOCK_EARLY: assert property ($rose(lockout_o) |-> fail_cnt >= LOCK_SHORT_CYC - 10)
    else $error("host locked out too early");
  AST_LOCK_LATE: assert property (fail_cnt > LONG_CYC + 8 |-> lockout_o)
    else $error("host lockout missing after long delay");
  AST_OPEN_DRAIN: assert property (pins_open_drain_o == standby_i)
    else $error("open drain does not follow standby");
  AST_SB_CLEAR: assert property (standby_clear_en_o |-> $past(standby_i) ##1 !standby_clear_en_o)
    else $error("standby clear pulse wrong");
  AST_FEB29: assert property (feb29_allow_o == (leapyear_count_o == 2'h0))
    else $error("february 29 enable wrong");
  AST_MFO_OSC: assert property (mfo_sel_i[1] |=> multi_function_pin_o == $past(osc_buf_i))
    else $error("multi function pin not oscillator");
  AST_OSC_FAIL: assert property (osc_fail_i |=> !clock_run_o)
    else $error("clock run survived oscillator fail");
  AST_TSAVE: assert property ($fell(power_fail_input_n_i) |=> !time_save_track_o)
    else $error("time save not frozen on power fail");
endmodule : tkc_top_checker

bind tkc_top tkc_top_checker #(.LONG_CYC(LONG_CYC)) u_chk (.*);

//--- testbench/tkc_host.sv
`timescale 1ns/1ps
module tkc_host (
  input wire logic mclk_i,
  output logic [5:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle bus from time zero
  initial begin
    addr_o = 6'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One strobe cycle; released data is inverted so a stale byte never matches
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d;
  endtask : xfer
endmodule : tkc_host

//--- testbench/tkc_top_test.sv
`timescale 1ns/1ps
module tkc_top_test;
  import tkc_pkg::*;
  localparam int LONG = 4000;
  logic mclk_i = 1'b0, reset_i = 1'b1, wr_i, rd_i;
  logic [5:0] addr_i;
  logic [7:0] wdata_i, rdata_o, r;
  logic power_fail_input_n_i = 1'b1, standby_i = 1'b0, osc_running_i = 1'b0, osc_fail_i = 1'b0;
  logic year_end_i = 1'b0, low_batt_i = 1'b1, pf_irq_en_i = 1'b1, osc_buf_i = 1'b0;
  logic ext_clk_i = 1'b0, gate_in_zero_i = 1'b0, gate_in_one_i = 1'b0;
  logic [5:0] rollover_i = 6'h00, int_tick_i = 6'h3f;
  logic [4:0] irq_src_i = 5'h00;
  logic [1:0] mfo_sel_i = 2'h0, leapyear_count_o, crystal_sel_o;
  logic main_irq_pin_o, multi_function_pin_o, timer0_wave_o, test_mode_en_o, single_supply_o;
  logic time_save_track_o, hour_12_mode_o, clock_run_o, feb29_allow_o, standby_clear_en_o;
  logic pins_open_drain_o, lockout_o, rd_d = 1'b0, w0, ok;
  logic [15:0] expq[$];
  logic [15:0] e;
  int miscompares = 0, tests_run = 0, seed = 32'h5807, n;

  tkc_host u_host (.mclk_i(mclk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  tkc_top #(.LONG_CYC(LONG), .PRE_W(4)) dut (.*);

  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) osc_buf_i <= 1'($random(seed));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    tests_run++;
    if (g !== ex) begin
      miscompares++;
      $display("Error %s exp %h got %h", nm, ex, g);
    end
  endtask : chk
  task automatic test_done;
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask : cyc
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d);
    cyc(1);
  endtask : wr
  // Note the masked expectation, then issue the read
  task automatic rd(input logic [5:0] a, input logic [7:0] ex, input logic [7:0] m);
    expq.push_back({m, ex & m});
    u_host.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic wait_lock(input logic lv, output int k);
    k = 0;
    while (lockout_o !== lv) begin
      @(posedge mclk_i);
      k++;
      if (k > 9000) begin
        miscompares++;
        test_done();
      end
    end
  endtask : wait_lock

  // Read data watcher: oldest note against the byte of the next cycle
  always @(posedge mclk_i) begin
    if (rd_d) begin
      e = expq.pop_front();
      chk("rdata", e[7:0], rdata_o & e[15:8]);
    end
    rd_d <= rd_i;
  end

  initial begin
    cyc(12);
    reset_i <= 1'b0;
    rd(OFS_PERIODIC, 8'h40, 8'hff);
    chk("supply", 8'h01, 8'(single_supply_o));
    rd(6'h3f, 8'h00, 8'hff);
    rd(OFS_STEERING, 8'h40, 8'h40);
    pf_irq_en_i <= 1'b0;
    rd(OFS_STEERING, 8'h00, 8'h40);
    wr(OFS_CLK_MODE, 8'h08);
    rd(OFS_CLK_MODE, 8'h00, 8'h08);
    osc_running_i <= 1'b1;
    for (int x = 0; x < 4; x++) begin
      r = {2'(x), 6'($random(seed))} | 8'h08;
      wr(OFS_CLK_MODE, r);
      rd(OFS_CLK_MODE, r, 8'hff);
      chk("xtal", 8'(x), 8'(crystal_sel_o));
      chk("h12", 8'(r[2]), 8'(hour_12_mode_o));
    end
    rd(OFS_PERIODIC, 8'h00, 8'h40);
    wr(OFS_CLK_MODE, 8'h0b);
    year_end_i <= 1'b1;
    cyc(1);
    year_end_i <= 1'b0;
    cyc(2);
    chk("leap", 8'h00, 8'(leapyear_count_o));
    osc_fail_i <= 1'b1;
    cyc(1);
    osc_fail_i <= 1'b0;
    cyc(2);
    chk("supply", 8'h01, 8'(single_supply_o));
    rd(OFS_PERIODIC, 8'h40, 8'h40);
    wr(OFS_PERIODIC, 8'h80);
    chk("test", 8'h01, 8'(test_mode_en_o));
    chk("supply", 8'h00, 8'(single_supply_o));
    // Test mode left off for normal running
    // host clears
    wr(OFS_PERIODIC, 8'h00);
    r = 8'($random(seed)) & 8'h3f;
    rollover_i <= r[5:0];
    cyc(1);
    rollover_i <= 6'h00;
    rd(OFS_PERIODIC, r, 8'h3f);
    rd(OFS_PERIODIC, 8'h00, 8'h3f);
    wr(OFS_TMR0_LSB, 8'h03);
    wr(OFS_TMR0_MSB, 8'h00);
    wr(OFS_TMR0_CTL, 8'h29);
    cyc(120);
    rd(OFS_TMR0_CTL, 8'h28, 8'hff);
    wr(OFS_TMR0_CTL, 8'h81);
    cyc(120);
    rd(OFS_TMR0_CTL, 8'h81, 8'h81);
    wr(OFS_TMR0_CTL, 8'h40);
    rd(OFS_TMR0_CTL, 8'h40, 8'h40);
    rd(OFS_TMR0_LSB, 8'h03, 8'hff);
    rd(OFS_TMR0_CTL, 8'h00, 8'h40);
    wr(OFS_TMR0_CTL, 8'h40);
    wr(OFS_TMR0_CTL, 8'h00);
    rd(OFS_TMR0_CTL, 8'h00, 8'h40);
    wr(OFS_TMR0_CTL, 8'h2f);
    w0 = timer0_wave_o;
    cyc(100);
    chk("wave", 8'(w0), 8'(timer0_wave_o));
    for (int x = 1; x < 3; x++) begin
      wr(OFS_TMR0_CTL, 8'haf);
      cyc(100);
      chk("wave", 8'(w0 ^ x[0]), 8'(timer0_wave_o));
    end
    for (int x = 0; x < 5; x++) begin
      wr(OFS_STEERING, 8'(1 << x));
      irq_src_i <= 5'(1 << x);
      cyc(3);
      chk("mfo", 8'h01, 8'(multi_function_pin_o));
      chk("irq", 8'h00, 8'(main_irq_pin_o));
      irq_src_i <= ~5'(1 << x);
      cyc(3);
      chk("mfo", 8'h00, 8'(multi_function_pin_o));
      chk("irq", 8'h01, 8'(main_irq_pin_o));
    end
    irq_src_i <= 5'h00;
    mfo_sel_i <= 2'h1;
    cyc(3);
    chk("mfo", 8'(timer0_wave_o), 8'(multi_function_pin_o));
    mfo_sel_i <= 2'h2;
    standby_i <= 1'b1;
    cyc(6);
    standby_i <= 1'b0;
    // Long delay, short delay, then host cuts the long delay short
    for (int x = 0; x < 3; x++) begin
      wr(OFS_STEERING, x == 1 ? 8'h80 : 8'ha0);
      chk("tsave", 8'h01, 8'(time_save_track_o));
      power_fail_input_n_i <= 1'b0;
      cyc(2);
      chk("tsave", 8'h00, 8'(time_save_track_o));
      if (x == 2) begin
        cyc(3800);
        wr(OFS_STEERING, 8'h00);
      end
      wait_lock(1'b1, n);
      ok = x == 0 ? (n > LONG - 9 && n < LONG + 9) : x == 1 ? (n > 3739 && n < 7880) : (n < 4);
      chk("lockdly", 8'h01, 8'(ok));
      wr(OFS_CLK_MODE, 8'hc4);
      rd(OFS_CLK_MODE, 8'h00, 8'hff);
      power_fail_input_n_i <= 1'b1;
      wait_lock(1'b0, n);
      rd(OFS_CLK_MODE, 8'h00, 8'hff);
    end
    cyc(3);
    test_done();
  end
endmodule : tkc_top_test
